// ==== hdl/uabd_top.v ====
/*
  Automatic bit-rate measurement for an asynchronous serial port, with
  the rate generator it reuses and an AXI4-Lite register slave.
  Assumes RX is already synchronous to MCLK; the transmitter and
  receiver datapaths sit outside and obey TX_LOAD and RX_HOLD_IDLE.
*/
// Operation
// - detect only in asynchronous mode, wake handled
// - enable clears counter, then awaits start bit
// - start bit with enable set begins measurement
// - counting starts at first rising edge
// - low and high bit times both timed
// - fifth rising edge leaves period in divisor
// - fifth rising edge clears enable bit
// - rollover FFFFh to 0000h sets overflow bit
// - overflow bit set by hardware, writable by software
// - rollover keeps detection running, enable stays set
// - measuring counter runs at one eighth rate
// - counter clock 512, 128 or 32 divisions
// - count spans both bytes at either width; software checks high
// - receive machine held idle during detection
// - fifth rising edge sets receive complete flag
// - receive data read clears complete flag
// - with wake enabled, measure byte after break
// - transmit data writes refused while enable set
// - normal generator gives 64x, 16x or 4x clock
`timescale 1ns/1ps
`include "uabd_defs.vh"
module uabd_top (
  input wire MCLK,
  input wire SYS_RST,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire RX,
  output reg RX_HOLD_IDLE,
  output reg RX_COMPLETE,
  output reg SAMPLE_TICK,
  output reg BIT_TICK,
  output reg TX_LOAD,
  output reg [7:0] TX_DATA
);
  localparam ST_IDLE = 3'h0;
  localparam ST_BRK_LOW = 3'h1;
  localparam ST_BRK_END = 3'h2;
  localparam ST_START = 3'h3;
  localparam ST_FIRST = 3'h4;
  localparam ST_COUNT = 3'h5;

  reg auto_detect_enable_r;
  reg wake_on_break_enable_r;
  reg wide_divisor_select_r;
  reg auto_detect_overflow_r;
  reg sync_mode_r;
  reg high_speed_select_r;
  reg port_enable_r;
  reg [15:0] divisor_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [2:0] edge_cnt_r;
  reg rx_d_r;
  reg [7:0] aw_addr_r;
  reg aw_full_r;
  reg [7:0] w_data_r;
  reg w_strb0_r;
  reg w_full_r;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg [15:0] nrm_cnt_r;
  reg [5:0] ovs_cnt_r;
  reg [5:0] ovs_limit;
  reg [`UABD_PRE_W-1:0] pre_limit;
  wire pre_tick;
  wire rx_rise;
  wire rx_fall;
  wire eligible;
  wire wr_go;
  wire wr_hit;
  wire rd_take;
  wire rx_data_read;
  wire done;
  wire [15:0] nrm_limit;

  // ------------------------------------------------------------
  // line edges and detection conditions
  // ------------------------------------------------------------
  assign rx_rise = RX & ~rx_d_r;
  assign rx_fall = ~RX & rx_d_r;
  assign eligible = auto_detect_enable_r & ~sync_mode_r;
  assign done = (st_r == ST_COUNT) && rx_rise && (edge_cnt_r == `UABD_EDGE_LAST);
  assign wr_go = aw_full_r & w_full_r & ~S_AXI_BVALID;
  assign rd_take = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rx_data_read = rd_take && (S_AXI_ARADDR == `UABD_OFS_RX_DATA);

  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_d_r <= 1'b1;
    end else begin
      rx_d_r <= RX;
    end
  end

  // ------------------------------------------------------------
  // measurement sequencer
  // ------------------------------------------------------------
  // leaving enable or going synchronous aborts at once, so a stuck
  // line cannot leave the receiver held forever
  always @* begin
    st_nxt = st_r;
    if (!eligible) begin
      st_nxt = ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          st_nxt = wake_on_break_enable_r ? ST_BRK_LOW : ST_START;
        end
        ST_BRK_LOW: begin
          if (rx_fall || !RX) begin
            st_nxt = ST_BRK_END;
          end
        end
        ST_BRK_END: begin
          if (rx_rise) begin
            st_nxt = ST_START;
          end
        end
        ST_START: begin
          if (!RX) begin
            st_nxt = ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (rx_rise) begin
            st_nxt = ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (done) begin
            st_nxt = ST_IDLE;
          end
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // state, edge count and held-idle output
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= ST_IDLE;
      edge_cnt_r <= 3'h0;
      RX_HOLD_IDLE <= 1'b0;
    end else begin
      st_r <= st_nxt;
      RX_HOLD_IDLE <= (st_nxt != ST_IDLE);
      if (st_r == ST_FIRST) begin
        edge_cnt_r <= 3'h1; // the rise that starts counting is the first of five
      end else if (st_r == ST_COUNT && rx_rise) begin
        edge_cnt_r <= edge_cnt_r + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // measurement clock: slow ticks only while counting
  // ------------------------------------------------------------
  // one eighth of the normal counter rate per mode
  always @* begin
    case ({wide_divisor_select_r, high_speed_select_r})
      2'b00: pre_limit = `UABD_PRE_DIV512;
      2'b11: pre_limit = `UABD_PRE_DIV32;
      default: pre_limit = `UABD_PRE_DIV128;
    endcase
  end

  uabd_prescaler #(
    .WIDTH(`UABD_PRE_W)
  ) u_pre (
    .clk(MCLK),
    .rst(SYS_RST),
    .clear(st_r != ST_COUNT),
    .run(st_r == ST_COUNT),
    .limit(pre_limit),
    .tick(pre_tick)
  );

  // ------------------------------------------------------------
  // register file with hardware side effects
  // ------------------------------------------------------------
  assign wr_hit = wr_go & w_strb0_r;

  // hardware updates follow software writes so that events win
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      auto_detect_enable_r <= 1'b0;
      wake_on_break_enable_r <= 1'b0;
      wide_divisor_select_r <= 1'b0;
      auto_detect_overflow_r <= 1'b0;
      sync_mode_r <= 1'b0;
      high_speed_select_r <= 1'b0;
      port_enable_r <= 1'b0;
      divisor_r <= `UABD_RST_DIV;
      RX_COMPLETE <= 1'b0;
      TX_LOAD <= 1'b0;
      TX_DATA <= `UABD_RST_BYTE;
    end else begin
      TX_LOAD <= 1'b0;
      if (wr_hit && aw_addr_r == `UABD_OFS_RATE_CTRL) begin
        auto_detect_enable_r <= w_data_r[`UABD_CTRL_ADEN];
        wake_on_break_enable_r <= w_data_r[`UABD_CTRL_WAKE];
        wide_divisor_select_r <= w_data_r[`UABD_CTRL_WIDE];
        auto_detect_overflow_r <= w_data_r[`UABD_CTRL_OVF];
      end
      if (wr_hit && aw_addr_r == `UABD_OFS_MODE) begin
        sync_mode_r <= w_data_r[`UABD_MODE_SYNC];
        high_speed_select_r <= w_data_r[`UABD_MODE_HSPD];
        port_enable_r <= w_data_r[`UABD_MODE_PEN];
      end
      if (wr_hit && aw_addr_r == `UABD_OFS_DIV_LOW) begin
        divisor_r[7:0] <= w_data_r;
      end
      if (wr_hit && aw_addr_r == `UABD_OFS_DIV_HIGH) begin
        divisor_r[15:8] <= w_data_r;
      end
      // the transmitter cannot run while its clock is borrowed
      if (wr_hit && aw_addr_r == `UABD_OFS_TX_DATA && !auto_detect_enable_r) begin
        TX_DATA <= w_data_r;
        TX_LOAD <= 1'b1;
      end
      if (rx_data_read) begin
        RX_COMPLETE <= 1'b0;
      end
      if (st_r == ST_IDLE && eligible) begin
        divisor_r <= `UABD_RST_DIV;
      end
      // full 16-bit count always; high byte shows an 8-bit carry
      if (st_r == ST_COUNT && pre_tick) begin
        divisor_r <= divisor_r + 16'h0001;
        if (divisor_r == `UABD_CNT_MAX) begin
          auto_detect_overflow_r <= 1'b1;
        end
      end
      if (done) begin
        auto_detect_enable_r <= 1'b0;
        RX_COMPLETE <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // normal rate generator, idle while measuring
  // ------------------------------------------------------------
  assign nrm_limit = wide_divisor_select_r ? divisor_r : {8'h00, divisor_r[7:0]};

  // sample ticks per bit: 64, 16, or 4 in high-speed wide mode
  always @* begin
    case ({wide_divisor_select_r, high_speed_select_r})
      2'b00: ovs_limit = `UABD_OVS_X64;
      2'b11: ovs_limit = `UABD_OVS_X4;
      default: ovs_limit = `UABD_OVS_X16;
    endcase
  end

  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      nrm_cnt_r <= 16'h0000;
      ovs_cnt_r <= 6'h00;
      SAMPLE_TICK <= 1'b0;
      BIT_TICK <= 1'b0;
    end else if (!port_enable_r || st_r != ST_IDLE) begin
      nrm_cnt_r <= 16'h0000;
      ovs_cnt_r <= 6'h00;
      SAMPLE_TICK <= 1'b0;
      BIT_TICK <= 1'b0;
    end else if (nrm_cnt_r >= nrm_limit) begin
      nrm_cnt_r <= 16'h0000;
      SAMPLE_TICK <= 1'b1;
      if (ovs_cnt_r >= ovs_limit) begin
        ovs_cnt_r <= 6'h00;
        BIT_TICK <= 1'b1;
      end else begin
        ovs_cnt_r <= ovs_cnt_r + 6'h01;
        BIT_TICK <= 1'b0;
      end
    end else begin
      nrm_cnt_r <= nrm_cnt_r + 16'h0001;
      SAMPLE_TICK <= 1'b0;
      BIT_TICK <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  // address and data are latched independently, either may lead
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `UABD_RESP_OKAY;
      aw_addr_r <= 8'h00;
      aw_full_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb0_r <= 1'b0;
      w_full_r <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr_r <= S_AXI_AWADDR;
        aw_full_r <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data_r <= S_AXI_WDATA[7:0];
        w_strb0_r <= S_AXI_WSTRB[0];
        w_full_r <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr_r == `UABD_OFS_RATE_CTRL ||
                        aw_addr_r == `UABD_OFS_MODE ||
                        aw_addr_r == `UABD_OFS_DIV_LOW ||
                        aw_addr_r == `UABD_OFS_DIV_HIGH ||
                        aw_addr_r == `UABD_OFS_RX_DATA ||
                        aw_addr_r == `UABD_OFS_TX_DATA ||
                        aw_addr_r == `UABD_OFS_STATUS) ?
                       `UABD_RESP_OKAY : `UABD_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  // receive data always reads zero: the measured byte is discarded
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR == `UABD_OFS_RATE_CTRL) begin
      rd_mux[`UABD_CTRL_ADEN] = auto_detect_enable_r;
      rd_mux[`UABD_CTRL_WAKE] = wake_on_break_enable_r;
      rd_mux[`UABD_CTRL_WIDE] = wide_divisor_select_r;
      rd_mux[`UABD_CTRL_RXIDLE] = ~RX_HOLD_IDLE;
      rd_mux[`UABD_CTRL_OVF] = auto_detect_overflow_r;
    end else if (S_AXI_ARADDR == `UABD_OFS_MODE) begin
      rd_mux[`UABD_MODE_SYNC] = sync_mode_r;
      rd_mux[`UABD_MODE_HSPD] = high_speed_select_r;
      rd_mux[`UABD_MODE_PEN] = port_enable_r;
    end else if (S_AXI_ARADDR == `UABD_OFS_DIV_LOW) begin
      rd_mux[7:0] = divisor_r[7:0];
    end else if (S_AXI_ARADDR == `UABD_OFS_DIV_HIGH) begin
      rd_mux[7:0] = divisor_r[15:8];
    end else if (S_AXI_ARADDR == `UABD_OFS_TX_DATA) begin
      rd_mux[7:0] = TX_DATA;
    end else if (S_AXI_ARADDR == `UABD_OFS_STATUS) begin
      rd_mux[`UABD_STAT_RCF] = RX_COMPLETE;
      rd_mux[`UABD_STAT_HOLD] = RX_HOLD_IDLE;
    end else if (S_AXI_ARADDR != `UABD_OFS_RX_DATA) begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `UABD_RESP_OKAY;
    end else begin
      if (rd_take) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_hit ? `UABD_RESP_OKAY : `UABD_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end
endmodule // uabd_top

// ==== hdl/uabd_defs.vh ====
/*
  Constants of the automatic rate-detection block: register offsets,
  field positions, reset values and divider counts.
  Assumes it is included by bare name from the design files under hdl/.
*/
`ifndef UABD_DEFS_VH
`define UABD_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define UABD_OFS_RATE_CTRL 8'h00
`define UABD_OFS_MODE 8'h04
`define UABD_OFS_DIV_LOW 8'h08
`define UABD_OFS_DIV_HIGH 8'h0C
`define UABD_OFS_RX_DATA 8'h10
`define UABD_OFS_TX_DATA 8'h14
`define UABD_OFS_STATUS 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UABD_CTRL_ADEN 0
`define UABD_CTRL_WAKE 1
`define UABD_CTRL_WIDE 3
`define UABD_CTRL_RXIDLE 6
`define UABD_CTRL_OVF 7
`define UABD_MODE_SYNC 0
`define UABD_MODE_HSPD 1
`define UABD_MODE_PEN 2
`define UABD_STAT_RCF 0
`define UABD_STAT_HOLD 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UABD_RST_BYTE 8'h00
`define UABD_RST_DIV 16'h0000

// ----------------------------------------------------------------
// counts: measurement prescale limits (divide minus one),
// oversample limits (ticks per bit minus one), rollover, edges
// ----------------------------------------------------------------
`define UABD_PRE_W 10
`define UABD_PRE_DIV512 10'h1FF
`define UABD_PRE_DIV128 10'h07F
`define UABD_PRE_DIV32 10'h01F
`define UABD_OVS_X64 6'h3F
`define UABD_OVS_X16 6'h0F
`define UABD_OVS_X4 6'h03
`define UABD_CNT_MAX 16'hFFFF
`define UABD_EDGE_LAST 3'h4

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define UABD_RESP_OKAY 2'h0
`define UABD_RESP_SLVERR 2'h2

`endif

// ==== hdl/uabd_prescaler.v ====
/*
  Free divider that gives one-cycle ticks while run is high.
  Assumes one clock MCLK domain; clear restarts the count from zero.
*/
`timescale 1ns/1ps
module uabd_prescaler #(
  parameter WIDTH = 10
) (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire run,
  input wire [WIDTH-1:0] limit,
  output reg tick
);
  reg [WIDTH-1:0] cnt_r;

  // ------------------------------------------------------------
  // counter: a tick every limit+1 running cycles
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (clear) begin
      cnt_r <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (run && cnt_r == limit) begin
      cnt_r <= {WIDTH{1'b0}};
      tick <= 1'b1;
    end else if (run) begin
      cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // uabd_prescaler

// ==== dv/uabd_top_sva.sv ====
/*
  Port-level checker for the rate-detection block and its register slave.
  Assumes the bind below sees uabd_top with its documented port names.
*/
`timescale 1ns/1ps
module uabd_top_sva (
  input wire MCLK,
  input wire SYS_RST,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire RX,
  input wire RX_HOLD_IDLE,
  input wire RX_COMPLETE,
  input wire SAMPLE_TICK,
  input wire BIT_TICK,
  input wire TX_LOAD,
  input wire [7:0] TX_DATA
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // --------------------
  // detection sequence
  // --------------------
  a_hold_blocks_tx: assert property (RX_HOLD_IDLE |-> !TX_LOAD)
    else $error("transmit load while detection runs");
  a_done_drops_hold: assert property ($rose(RX_COMPLETE) |-> $past(RX_HOLD_IDLE) ##1 !RX_HOLD_IDLE)
    else $error("complete flag not tied to end of detection");
  a_done_on_high: assert property ($rose(RX_COMPLETE) |-> RX)
    else $error("complete flag raised while line low");
  // a generator tick while held would mean the counter is shared wrongly
  a_gen_quiet: assert property (RX_HOLD_IDLE && $past(RX_HOLD_IDLE) |-> !SAMPLE_TICK && !BIT_TICK)
    else $error("rate generator ticking during detection");
  a_flag_read_clr: assert property ($fell(RX_COMPLETE) |-> S_AXI_RVALID || $past(S_AXI_RVALID))
    else $error("complete flag cleared without a read");
  a_txdata_cause: assert property ($changed(TX_DATA) |-> TX_LOAD)
    else $error("transmit byte changed without a load");

  // --------------------
  // register bus timing
  // --------------------
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
endmodule // uabd_top_sva

bind uabd_top uabd_top_sva u_sva (.*);

// ==== dv/uabd_sender.sv ====
/*
  Remote serial sender: frames one byte, optionally after a long break.
  Assumes the caller enters send just after a rising edge of clk.
*/
`timescale 1ns/1ps
module uabd_sender (
  input wire clk,
  output logic rx
);
  // line idles high, as a pulled-up serial line does
  initial rx = 1'b1;

  // --------------------
  // framing
  // --------------------
  task automatic send(input int bc, input logic [7:0] val, input logic brk);
    logic [9:0] fr;
    fr = {1'b1, val, 1'b0};
    if (brk) begin
      rx <= 1'b0;
      repeat (13 * bc) @(posedge clk);
      rx <= 1'b1;
      repeat (bc) @(posedge clk);
    end
    // start, eight bits lsb first, stop; 55h gives five rising edges
    for (int i = 0; i < 10; i++) begin
      rx <= fr[i];
      repeat (bc) @(posedge clk);
    end
  endtask
endmodule // uabd_sender

// ==== dv/uabd_top_tb.sv ====
/*
  Self-checking bench: register-bus tasks, measurement runs in every
  counter clock mode, overflow, transmit refusal and the normal generator.
  Assumes the design header is reachable by bare name.
*/
`timescale 1ns/1ps
`include "uabd_defs.vh"
module uabd_top_tb;
  logic mclk, sys_rst, awv, wv, bre, arv, rre;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, v;
  logic [1:0] rsp;
  wire awrdy, wrdy, bvld, arrdy, rvld, rx, hold, done, stk, btk, txl;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] txd;
  int err_count, check_count, cyc, tx_n, n, ns;
  int ptab[4] = '{512, 128, 128, 32};
  int btab[4] = '{64, 16, 16, 4};

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  uabd_top DUT (.MCLK(mclk), .SYS_RST(sys_rst), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvld), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvld), .S_AXI_RREADY(rre), .RX(rx),
    .RX_HOLD_IDLE(hold), .RX_COMPLETE(done), .SAMPLE_TICK(stk), .BIT_TICK(btk),
    .TX_LOAD(txl), .TX_DATA(txd));
  uabd_sender snd (.clk(mclk), .rx(rx));

  // --------------------
  // bus tasks and compares
  // --------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    aw_a <= a;
    w_d <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    // address and data may be taken on different edges
    do begin
      @(posedge mclk);
      if (awv && awrdy === 1'b1) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wrdy === 1'b1) begin
        wd = 1'b1;
        wv <= 1'b0;
      end
    end while (!(ad && wd));
    do @(posedge mclk); while (bvld !== 1'b1);
    bre <= 1'b0;
    rsp = bresp;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    ar_a <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge mclk); while (arrdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge mclk); while (rvld !== 1'b1);
    rre <= 1'b0;
    d = rdata;
    rsp = rresp;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  // a measured count may land one either side, depending on prescaler phase
  task chk_near(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e && g !== e + 1 && g !== e - 1) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  // cycles and sample ticks between two bit ticks of the normal generator
  task per(output int c, output int s);
    c = 0;
    s = 0;
    do @(posedge mclk); while (btk !== 1'b1);
    do begin
      @(posedge mclk);
      c++;
      if (stk === 1'b1) s++;
    end while (btk !== 1'b1);
  endtask

  // one sync byte at two prescaler periods per bit: the count should be 16
  task meas(input logic [1:0] ws, input logic wk, input int p);
    logic [31:0] lo, hi;
    // port enabled so the generator would tick if it were not held off
    wr(`UABD_OFS_MODE, {29'h0, 1'b1, ws[0], 1'b0});
    wr(`UABD_OFS_RATE_CTRL, {28'h0, ws[1], 1'b0, wk, 1'b1});
    rd(`UABD_OFS_DIV_LOW, lo);
    chk("div_cleared", 32'h0, lo);
    rd(`UABD_OFS_STATUS, lo);
    chk("hold_idle", 32'h2, lo);
    snd.send(2 * p, 8'h55, wk);
    chk("complete", 32'h1, {31'h0, done});
    rd(`UABD_OFS_RATE_CTRL, lo);
    chk("enable_done", 32'h40, lo & 32'h41);
    rd(`UABD_OFS_DIV_LOW, lo);
    rd(`UABD_OFS_DIV_HIGH, hi);
    chk("div_high", 32'h0, hi);
    chk_near("divisor", 32'h10, {16'h0, hi[7:0], lo[7:0]});
    rd(`UABD_OFS_RX_DATA, lo);
    chk("complete_clr", 32'h0, {31'h0, done});
  endtask

  task print_verdict;
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // --------------------
  // monitors and watchdog
  // --------------------
  always @(posedge mclk) begin
    if (txl === 1'b1) tx_n <= tx_n + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      print_verdict;
    end
  end

  // --------------------
  // main sequence
  // --------------------
  initial begin
    sys_rst = 1'b1;
    {awv, wv, bre, arv, rre} = 5'h00;
    aw_a = 8'h00;
    ar_a = 8'h00;
    w_d = 32'h0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(`UABD_OFS_RATE_CTRL, v);
    chk("ctrl_reset", 32'h40, v);
    rd(8'h1C, v);
    chk("unmapped", {30'h0, `UABD_RESP_SLVERR}, {30'h0, rsp});
    for (int m = 0; m < 4; m++) meas(m[1:0], 1'b0, ptab[m]);
    meas(2'h3, 1'b1, 32);
    // overflow: preload the divisor mid-count so the next step rolls over
    wr(`UABD_OFS_MODE, 32'h2);
    wr(`UABD_OFS_RATE_CTRL, 32'h09);
    fork
      snd.send(64, 8'h55, 1'b0);
      begin
        repeat (100) @(posedge mclk);
        wr(`UABD_OFS_DIV_HIGH, 32'hFF);
        wr(`UABD_OFS_DIV_LOW, 32'hFF);
        repeat (40) @(posedge mclk);
        rd(`UABD_OFS_RATE_CTRL, v);
        chk("ovf_running", 32'h81, v & 32'h81);
      end
    join
    rd(`UABD_OFS_RATE_CTRL, v);
    chk("ovf_done", 32'hC8, v);
    wr(`UABD_OFS_RATE_CTRL, 32'h08);
    rd(`UABD_OFS_RATE_CTRL, v);
    chk("ovf_sw_clear", 32'h48, v);
    wr(`UABD_OFS_RATE_CTRL, 32'h88);
    rd(`UABD_OFS_RATE_CTRL, v);
    chk("ovf_sw_set", 32'hC8, v);
    rd(`UABD_OFS_RX_DATA, v);
    // transmit writes are dropped while detection is armed
    wr(`UABD_OFS_RATE_CTRL, 32'h01);
    wr(`UABD_OFS_TX_DATA, 32'h5A);
    chk("tx_resp", {30'h0, `UABD_RESP_OKAY}, {30'h0, rsp});
    // the load counter updates one edge after the pulse is seen
    @(posedge mclk);
    chk("tx_refused", 32'h0, tx_n);
    rd(`UABD_OFS_TX_DATA, v);
    chk("tx_kept", 32'h0, v);
    wr(`UABD_OFS_RATE_CTRL, 32'h00);
    wr(`UABD_OFS_TX_DATA, 32'hA5);
    @(posedge mclk);
    chk("tx_loads", 32'h1, tx_n);
    chk("tx_byte", 32'hA5, {24'h0, txd});
    wr(`UABD_OFS_MODE, 32'h1);
    wr(`UABD_OFS_RATE_CTRL, 32'h01);
    rd(`UABD_OFS_STATUS, v);
    chk("sync_blocks", 32'h0, v);
    wr(`UABD_OFS_RATE_CTRL, 32'h00);
    // normal generator with divisor 3: four cycles per sample tick
    wr(`UABD_OFS_DIV_LOW, 32'h03);
    wr(`UABD_OFS_DIV_HIGH, 32'h00);
    for (int m = 0; m < 4; m++) begin
      wr(`UABD_OFS_RATE_CTRL, {28'h0, m[1], 3'h0});
      wr(`UABD_OFS_MODE, {29'h0, 1'b1, m[0], 1'b0});
      per(n, ns);
      chk("bit_period", 4 * btab[m], n);
      chk("sample_ticks", btab[m], ns);
    end
    print_verdict;
  end
endmodule // uabd_top_tb
